/* File: logic/rtcac_regs.svh */
`ifndef RTCAC_REGS_SVH
`define RTCAC_REGS_SVH

// Register indices; byte address is four times the index
`define RTCAC_IDX_ALM_SEC   10'h0E8
`define RTCAC_IDX_ALM_MIN   10'h0E9
`define RTCAC_IDX_ALM_HRS   10'h0EA
`define RTCAC_IDX_ALM_DOW   10'h0EB
`define RTCAC_IDX_ALM_EN    10'h0EC
`define RTCAC_IDX_CTRL      10'h0ED

// Control register fields
`define RTCAC_CTRL_ALARM    7
`define RTCAC_CTRL_INT_EN   6
`define RTCAC_CTRL_BCD      5
`define RTCAC_CTRL_CLK_SEL  4
`define RTCAC_CTRL_FREQ     3
`define RTCAC_CTRL_DST      2
`define RTCAC_CTRL_SLP      1
`define RTCAC_CTRL_UNLOCK   0

// Field enable positions
`define RTCAC_EN_DOW        3
`define RTCAC_EN_HRS        2
`define RTCAC_EN_MIN        1
`define RTCAC_EN_SEC        0

// Reset values
`define RTCAC_ALM_RST       8'h00
`define RTCAC_EN_RST        4'h0

// Prescaler divides (edges per second)
`define RTCAC_XTAL_DIV      16'h8000
`define RTCAC_LINE60_DIV    16'h003C
`define RTCAC_LINE50_DIV    16'h0032

// Bus responses
`define RTCAC_RESP_OKAY     2'h0
`define RTCAC_RESP_SLVERR   2'h2

`endif

/* File: logic/rtcac_pkg.sv */
package rtcac_pkg;
	typedef enum logic {RTCAC_RD_IDLE, RTCAC_RD_DATA} rtcac_rd_state_t;
	typedef logic [7:0] rtcac_byte_t;
	typedef logic [3:0] rtcac_field_en_t;
endpackage : rtcac_pkg

/* File: logic/rtcac_alarm_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_regs.svh"
module rtcac_alarm_cmp
	import rtcac_pkg::*;
(
	input  wire rtcac_field_en_t field_en,
	input  wire rtcac_byte_t     alm_sec,
	input  wire rtcac_byte_t     alm_min,
	input  wire rtcac_byte_t     alm_hrs,
	input  wire logic [3:0]      alm_dow,
	input  wire rtcac_byte_t     cur_sec,
	input  wire rtcac_byte_t     cur_min,
	input  wire rtcac_byte_t     cur_hrs,
	input  wire rtcac_byte_t     cur_dow,
	output logic                 match
);
	function automatic logic field_ok(input logic en, input rtcac_byte_t a, input rtcac_byte_t b);
		return !en || (a == b);
	endfunction : field_ok

	// Raw byte compare works for both number formats
	always_comb begin
		match = (|field_en)
			&& field_ok(field_en[`RTCAC_EN_SEC], alm_sec, cur_sec)
			&& field_ok(field_en[`RTCAC_EN_MIN], alm_min, cur_min)
			&& field_ok(field_en[`RTCAC_EN_HRS], alm_hrs, cur_hrs)
			&& field_ok(field_en[`RTCAC_EN_DOW], {4'h0, alm_dow}, {4'h0, cur_dow[3:0]});
	end
endmodule : rtcac_alarm_cmp
`default_nettype wire

/* File: logic/rtcac_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_regs.svh"
module rtcac_prescaler
	import rtcac_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic restart,
	input  wire logic run,
	input  wire logic clk_sel,
	input  wire logic line_frequency_select,
	input  wire logic xtal_edge,
	input  wire logic line_edge,
	output logic      tick_r
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [15:0] lim;
	logic        tick_nxt;
	logic        src_edge;

	always_comb begin
		lim = clk_sel ? (line_frequency_select ? `RTCAC_LINE50_DIV : `RTCAC_LINE60_DIV) : `RTCAC_XTAL_DIV;
		src_edge = clk_sel ? line_edge : xtal_edge;
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (restart || !run) begin
			cnt_nxt = 16'h0000;
		end else if (src_edge) begin
			if (cnt_r == lim - 16'h0001) begin
				cnt_nxt = 16'h0000;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
endmodule : rtcac_prescaler
`default_nettype wire

/* File: logic/rtcac_top.sv */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_regs.svh"
module rtcac_top
	import rtcac_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        por_n,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        xtal_in,
	input  wire logic        line_in,
	input  wire logic        sleep_active,
	input  wire logic        time_incr,
	input  wire rtcac_byte_t cur_sec,
	input  wire rtcac_byte_t cur_min,
	input  wire rtcac_byte_t cur_hrs,
	input  wire rtcac_byte_t cur_dow,
	output logic             counter_unlock,
	output logic             bcd_mode,
	output logic             osc_enable,
	output logic             sec_tick,
	output logic             alarm_irq,
	output logic             wake_request
);
	function automatic logic idx_hit(input logic [11:0] addr, input logic [9:0] idx);
		return addr[11:2] == idx;
	endfunction : idx_hit

	// Pin synchronisers
	logic [2:0] xtal_sync_r;
	logic [2:0] line_sync_r;
	logic       xtal_edge;
	logic       line_edge;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xtal_sync_r <= 3'h0;
			line_sync_r <= 3'h0;
		end else begin
			xtal_sync_r <= {xtal_sync_r[1:0], xtal_in};
			line_sync_r <= {line_sync_r[1:0], line_in};
		end
	end
	assign xtal_edge = xtal_sync_r[1] && !xtal_sync_r[2];
	assign line_edge = line_sync_r[1] && !line_sync_r[2];

	// Write channel
	logic        aw_held_r, aw_held_nxt;
	logic        w_held_r, w_held_nxt;
	logic [11:0] waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;
	logic        bvalid_nxt, awready_nxt, wready_nxt;
	logic [1:0]  bresp_nxt;
	logic        wr_do;
	logic        wr_lane;
	logic        wr_hit;

	always_comb begin
		aw_held_nxt = aw_held_r || (s_axi_awvalid && s_axi_awready);
		w_held_nxt = w_held_r || (s_axi_wvalid && s_axi_wready);
		waddr_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : waddr_r;
		wdata_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_r;
		wstrb_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_r;
		bvalid_nxt = s_axi_bvalid && !s_axi_bready;
		bresp_nxt = s_axi_bresp;
		wr_do = aw_held_r && w_held_r && !s_axi_bvalid;
		wr_hit = 1'b0;
		for (int i = 0; i < 6; i++) begin
			wr_hit = wr_hit || idx_hit(waddr_r, `RTCAC_IDX_ALM_SEC + 10'(i));
		end
		wr_lane = wr_do && wr_hit && wstrb_r[0];
		if (wr_do) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? `RTCAC_RESP_OKAY : `RTCAC_RESP_SLVERR;
		end
		awready_nxt = !aw_held_nxt && !bvalid_nxt && !wr_do;
		wready_nxt = !w_held_nxt && !bvalid_nxt && !wr_do;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RTCAC_RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready <= wready_nxt;
		end
	end

	// Register file
	rtcac_byte_t     alm_sec_r, alm_sec_nxt;
	rtcac_byte_t     alm_min_r, alm_min_nxt;
	rtcac_byte_t     alm_hrs_r, alm_hrs_nxt;
	logic [3:0]      alm_dow_r, alm_dow_nxt;
	rtcac_field_en_t alm_en_r, alm_en_nxt;
	logic            alarm_r, alarm_nxt;
	logic [5:2]      ctl_r, ctl_nxt;
	logic            slp_r, slp_nxt;
	logic            unlock_r, unlock_nxt;
	logic            irq_nxt, wake_nxt;
	logic            alarm_irq_en_r, int_en_nxt;
	logic            ctrl_wr, ctrl_rd, lock_evt, match, alarm_set;
	rtcac_byte_t     wbyte;

	assign wbyte = wdata_r[7:0];
	assign ctrl_wr = wr_lane && idx_hit(waddr_r, `RTCAC_IDX_CTRL);

	always_comb begin
		alm_sec_nxt = alm_sec_r;
		alm_min_nxt = alm_min_r;
		alm_hrs_nxt = alm_hrs_r;
		alm_dow_nxt = alm_dow_r;
		alm_en_nxt = alm_en_r;
		ctl_nxt = ctl_r;
		unlock_nxt = unlock_r;
		if (wr_lane) begin
			if (idx_hit(waddr_r, `RTCAC_IDX_ALM_SEC)) alm_sec_nxt = wbyte;
			if (idx_hit(waddr_r, `RTCAC_IDX_ALM_MIN)) alm_min_nxt = wbyte;
			if (idx_hit(waddr_r, `RTCAC_IDX_ALM_HRS)) alm_hrs_nxt = wbyte;
			if (idx_hit(waddr_r, `RTCAC_IDX_ALM_DOW) && unlock_r) alm_dow_nxt = wbyte[3:0];
			if (idx_hit(waddr_r, `RTCAC_IDX_ALM_EN)) alm_en_nxt = wbyte[3:0];
		end
		if (ctrl_wr) begin
			ctl_nxt = wbyte[`RTCAC_CTRL_BCD:`RTCAC_CTRL_DST];
			unlock_nxt = wbyte[`RTCAC_CTRL_UNLOCK];
		end
	end

	// Flags: a set in the same cycle as the clearing read wins
	assign lock_evt = ctrl_wr && unlock_r && !wbyte[`RTCAC_CTRL_UNLOCK];
	assign alarm_set = (time_incr || lock_evt) && match;
	always_comb begin
		alarm_nxt = (alarm_r && !ctrl_rd) || alarm_set;
		slp_nxt = (slp_r && !ctrl_rd) || (alarm_set && sleep_active);
		wake_nxt = alarm_set && sleep_active;
		irq_nxt = alarm_nxt && (ctrl_wr ? wbyte[`RTCAC_CTRL_INT_EN] : alarm_irq_en_r);
	end

	assign int_en_nxt = ctrl_wr ? wbyte[`RTCAC_CTRL_INT_EN] : alarm_irq_en_r;

	// System reset keeps alarm values, format bits and sleep flag
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			alm_sec_r <= `RTCAC_ALM_RST;
			alm_min_r <= `RTCAC_ALM_RST;
			alm_hrs_r <= `RTCAC_ALM_RST;
			alm_dow_r <= 4'h0;
			ctl_r <= 4'h0;
			slp_r <= 1'b0;
		end else begin
			alm_sec_r <= alm_sec_nxt;
			alm_min_r <= alm_min_nxt;
			alm_hrs_r <= alm_hrs_nxt;
			alm_dow_r <= alm_dow_nxt;
			ctl_r <= ctl_nxt;
			slp_r <= aresetn ? slp_nxt : slp_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !por_n) begin
			alm_en_r <= `RTCAC_EN_RST;
			alarm_r <= 1'b0;
			alarm_irq_en_r <= 1'b0;
			unlock_r <= 1'b0;
			alarm_irq <= 1'b0;
			wake_request <= 1'b0;
			counter_unlock <= 1'b0;
			bcd_mode <= 1'b0;
			osc_enable <= 1'b0;
		end else begin
			alm_en_r <= alm_en_nxt;
			alarm_r <= alarm_nxt;
			alarm_irq_en_r <= int_en_nxt;
			unlock_r <= unlock_nxt;
			alarm_irq <= irq_nxt;
			wake_request <= wake_nxt;
			counter_unlock <= unlock_nxt;
			bcd_mode <= ctl_nxt[`RTCAC_CTRL_BCD];
			osc_enable <= !ctl_nxt[`RTCAC_CTRL_CLK_SEL];
		end
	end

	rtcac_alarm_cmp u_cmp (
		.field_en (alm_en_r),
		.alm_sec  (alm_sec_r),
		.alm_min  (alm_min_r),
		.alm_hrs  (alm_hrs_r),
		.alm_dow  (alm_dow_r),
		.cur_sec  (cur_sec),
		.cur_min  (cur_min),
		.cur_hrs  (cur_hrs),
		.cur_dow  (cur_dow),
		.match    (match)
	);

	rtcac_prescaler u_presc (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.restart   (ctrl_wr),
		.run       (!unlock_r),
		.clk_sel   (ctl_r[`RTCAC_CTRL_CLK_SEL]),
		.line_frequency_select  (ctl_r[`RTCAC_CTRL_FREQ]),
		.xtal_edge (xtal_edge),
		.line_edge (line_edge),
		.tick_r    (sec_tick)
	);

	// Read channel
	rtcac_rd_state_t rd_state_r, rd_state_nxt;
	logic [31:0]     rdata_nxt;
	logic [1:0]      rresp_nxt;
	logic            ar_take;
	logic [11:0]     ra;

	assign ar_take = (rd_state_r == RTCAC_RD_IDLE) && s_axi_arvalid && s_axi_arready;
	assign ra = s_axi_araddr;
	assign ctrl_rd = ar_take && idx_hit(ra, `RTCAC_IDX_CTRL);

	always_comb begin
		rd_state_nxt = rd_state_r;
		rdata_nxt = s_axi_rdata;
		rresp_nxt = s_axi_rresp;
		case (rd_state_r)
			RTCAC_RD_IDLE: begin
				if (ar_take) begin
					rd_state_nxt = RTCAC_RD_DATA;
					rresp_nxt = `RTCAC_RESP_OKAY;
					rdata_nxt = 32'h0000_0000;
					if (idx_hit(ra, `RTCAC_IDX_ALM_SEC)) rdata_nxt[7:0] = alm_sec_r;
					else if (idx_hit(ra, `RTCAC_IDX_ALM_MIN)) rdata_nxt[7:0] = alm_min_r;
					else if (idx_hit(ra, `RTCAC_IDX_ALM_HRS)) rdata_nxt[7:0] = alm_hrs_r;
					else if (idx_hit(ra, `RTCAC_IDX_ALM_DOW)) rdata_nxt[3:0] = alm_dow_r;
					else if (idx_hit(ra, `RTCAC_IDX_ALM_EN)) rdata_nxt[3:0] = alm_en_r;
					else if (idx_hit(ra, `RTCAC_IDX_CTRL)) rdata_nxt[7:0] =
						{alarm_r, alarm_irq_en_r, ctl_r, slp_r, unlock_r};
					else rresp_nxt = `RTCAC_RESP_SLVERR;
				end
			end
			RTCAC_RD_DATA: begin
				if (s_axi_rready) rd_state_nxt = RTCAC_RD_IDLE;
			end
			default: rd_state_nxt = RTCAC_RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_r <= RTCAC_RD_IDLE;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RTCAC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			rd_state_r <= rd_state_nxt;
			s_axi_rdata <= rdata_nxt;
			s_axi_rresp <= rresp_nxt;
			s_axi_rvalid <= rd_state_nxt == RTCAC_RD_DATA;
			s_axi_arready <= rd_state_nxt == RTCAC_RD_IDLE;
		end
	end

	// Checks
	AST_READ_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_rd && !alarm_set) |=> (!alarm_r && !alarm_irq))
		else $error("Control read did not clear alarm");
	AST_IRQ_TRACK: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_irq == (alarm_r && alarm_irq_en_r))
		else $error("Interrupt does not follow flag and enable");
	AST_DOW_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
		(wr_lane && idx_hit(waddr_r, `RTCAC_IDX_ALM_DOW) && !unlock_r) |=> $stable(alm_dow_r))
		else $error("Weekday alarm written while locked");
	AST_EN_UPPER_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		(ar_take && idx_hit(ra, `RTCAC_IDX_ALM_EN)) |=> (s_axi_rvalid && s_axi_rdata[31:4] == 28'h0))
		else $error("Enable register upper bits not zero");
	AST_NO_EN_NO_MATCH: assert property (@(posedge aclk) disable iff (!aresetn)
		(alm_en_r == 4'h0) |-> !match)
		else $error("Match with no field enabled");
	AST_LOCK_EVAL: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
		(lock_evt && match) |=> alarm_r ##1 (alarm_r || $past(ctrl_rd)))
		else $error("Lock did not raise alarm");
	AST_INCR_EVAL: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
		(time_incr && match) |=> alarm_r)
		else $error("Increment did not raise alarm");
	AST_PRESC_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_wr |=> !sec_tick [*3])
		else $error("Tick soon after prescaler restart");
	AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
		(alarm_set && sleep_active) |=> (slp_r && wake_request) ##1 !wake_request)
		else $error("Alarm wake not flagged");
endmodule : rtcac_top
`default_nettype wire

/* File: test/rtcac_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcac_host (
	input  wire logic        aclk,
	output logic [11:0]      s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [11:0]      s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		s_axi_awaddr  = 12'h000;
		s_axi_awvalid = 1'b0;
		s_axi_wdata   = 32'h0;
		s_axi_wstrb   = 4'h0;
		s_axi_wvalid  = 1'b0;
		s_axi_bready  = 1'b0;
		s_axi_araddr  = 12'h000;
		s_axi_arvalid = 1'b0;
		s_axi_rready  = 1'b0;
	end
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd
endmodule : rtcac_host
`default_nettype wire

/* File: test/rtc_alarm_compare_and_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_regs.svh"
module rtc_alarm_compare_and_control_tb
	import rtcac_pkg::*;
;
	logic        aclk, aresetn, por_n, xtal_in, line_in, sleep_active, time_incr;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        counter_unlock, bcd_mode, osc_enable, sec_tick, alarm_irq, wake_request;
	rtcac_byte_t cur [4];
	int          err_total, tests_run;
	int          tick_cnt = 0;
	int          wake_cnt = 0;

	rtcac_top uut (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .xtal_in, .line_in, .sleep_active, .time_incr, .cur_sec(cur[0]), .cur_min(cur[1]),
		.cur_hrs(cur[2]), .cur_dow(cur[3]), .counter_unlock, .bcd_mode, .osc_enable, .sec_tick,
		.alarm_irq, .wake_request);
	rtcac_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (sec_tick === 1'b1) tick_cnt <= tick_cnt + 1;
		if (wake_request === 1'b1) wake_cnt <= wake_cnt + 1;
	end

	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task wreg(input logic [9:0] idx, input logic [31:0] d);
		logic [1:0] r;
		host.wr({idx, 2'b00}, d, r);
	endtask : wreg
	task rchk(input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		host.rd({idx, 2'b00}, d, r);
		chk(d, exp);
	endtask : rchk
	task wait1;
		@(posedge aclk);
		#1;
	endtask : wait1
	task rst_pulse;
		@(posedge aclk) aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : rst_pulse
	task pulse_incr;
		@(posedge aclk) time_incr <= 1'b1;
		@(posedge aclk) time_incr <= 1'b0;
		repeat (3) @(posedge aclk);
		#1;
	endtask : pulse_incr
	task line_edges(input int n);
		for (int k = 0; k < n; k++) begin
			line_in <= 1'b1;
			repeat (4) @(posedge aclk);
			line_in <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask : line_edges

	task t_reset;
		rchk(`RTCAC_IDX_ALM_EN, 32'h0);
		rchk(`RTCAC_IDX_ALM_DOW, 32'h0);
		wait1;
		chk(alarm_irq, 1'b0);
		$display("reset test done");
	endtask : t_reset
	task t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		wreg(`RTCAC_IDX_ALM_SEC, 32'h59);
		wreg(`RTCAC_IDX_ALM_MIN, 32'h3B);
		wreg(`RTCAC_IDX_ALM_HRS, 32'h23);
		wreg(`RTCAC_IDX_ALM_EN, 32'hFF);
		rchk(`RTCAC_IDX_ALM_SEC, 32'h59);
		rchk(`RTCAC_IDX_ALM_MIN, 32'h3B);
		rchk(`RTCAC_IDX_ALM_HRS, 32'h23);
		rchk(`RTCAC_IDX_ALM_EN, 32'h0F);
		host.wr(12'hFF0, 32'h1, r);
		chk(r, `RTCAC_RESP_SLVERR);
		host.rd(12'hFF0, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, `RTCAC_RESP_SLVERR});
		$display("register test done");
	endtask : t_regs
	task t_dow;
		wreg(`RTCAC_IDX_ALM_DOW, 32'h05);
		rchk(`RTCAC_IDX_ALM_DOW, 32'h0);
		wreg(`RTCAC_IDX_CTRL, 32'h01);
		wait1;
		chk(counter_unlock, 1'b1);
		wreg(`RTCAC_IDX_ALM_DOW, 32'hF7);
		rchk(`RTCAC_IDX_ALM_DOW, 32'h07);
		wreg(`RTCAC_IDX_CTRL, 32'h00);
		wait1;
		chk(counter_unlock, 1'b0);
		rst_pulse;
		rchk(`RTCAC_IDX_ALM_SEC, 32'h59);
		rchk(`RTCAC_IDX_ALM_EN, 32'h0);
		rchk(`RTCAC_IDX_ALM_DOW, 32'h07);
		$display("weekday and keep test done");
	endtask : t_dow
	task t_alarm;
		@(posedge aclk) cur <= '{8'h59, 8'h3B, 8'h23, 8'h07};
		wreg(`RTCAC_IDX_CTRL, 32'h40);
		pulse_incr;
		chk(alarm_irq, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wreg(`RTCAC_IDX_ALM_EN, {28'h0, 4'h1 << i});
			@(posedge aclk) cur[i] <= cur[i] ^ 8'h01;
			pulse_incr;
			chk(alarm_irq, 1'b0);
			@(posedge aclk) cur[i] <= cur[i] ^ 8'h01;
			pulse_incr;
			chk(alarm_irq, 1'b1);
			rchk(`RTCAC_IDX_CTRL, 32'hC0);
			wait1;
			chk(alarm_irq, 1'b0);
		end
		wreg(`RTCAC_IDX_CTRL, 32'h00);
		pulse_incr;
		chk(alarm_irq, 1'b0);
		rchk(`RTCAC_IDX_CTRL, 32'h80);
		wreg(`RTCAC_IDX_CTRL, 32'h01);
		wreg(`RTCAC_IDX_CTRL, 32'h00);
		rchk(`RTCAC_IDX_CTRL, 32'h80);
		$display("alarm test done");
	endtask : t_alarm
	task t_sleep;
		int base;
		@(posedge aclk) sleep_active <= 1'b1;
		base = wake_cnt;
		pulse_incr;
		chk(wake_cnt - base, 1);
		@(posedge aclk) sleep_active <= 1'b0;
		rst_pulse;
		rchk(`RTCAC_IDX_CTRL, 32'h02);
		rchk(`RTCAC_IDX_CTRL, 32'h00);
		$display("sleep test done");
	endtask : t_sleep
	task t_ctrl;
		wreg(`RTCAC_IDX_CTRL, 32'h20);
		wait1;
		chk({bcd_mode, osc_enable}, 2'b11);
		wreg(`RTCAC_IDX_CTRL, 32'h82);
		rchk(`RTCAC_IDX_CTRL, 32'h00);
		wreg(`RTCAC_IDX_CTRL, 32'h10);
		wait1;
		chk({bcd_mode, osc_enable}, 2'b00);
		$display("control test done");
	endtask : t_ctrl
	task t_presc;
		int base;
		wreg(`RTCAC_IDX_CTRL, 32'h10);
		base = tick_cnt;
		line_edges(59);
		chk(tick_cnt - base, 0);
		line_edges(1);
		chk(tick_cnt - base, 1);
		wreg(`RTCAC_IDX_CTRL, 32'h18);
		base = tick_cnt;
		line_edges(25);
		wreg(`RTCAC_IDX_CTRL, 32'h18);
		line_edges(49);
		chk(tick_cnt - base, 0);
		line_edges(1);
		chk(tick_cnt - base, 1);
		$display("prescaler test done");
	endtask : t_presc
	task t_xtal;
		int base;
		wreg(`RTCAC_IDX_CTRL, 32'h00);
		base = tick_cnt;
		repeat (2 * (`RTCAC_XTAL_DIV - 1)) @(posedge aclk) xtal_in <= ~xtal_in;
		repeat (8) @(posedge aclk);
		chk(tick_cnt - base, 0);
		repeat (2) @(posedge aclk) xtal_in <= ~xtal_in;
		repeat (8) @(posedge aclk);
		chk(tick_cnt - base, 1);
		$display("crystal prescaler test done");
	endtask : t_xtal

	initial begin
		repeat (80000) @(posedge aclk);
		err_total++;
		give_verdict;
	end
	initial begin
		aresetn      = 1'b0;
		por_n        = 1'b0;
		xtal_in      = 1'b0;
		line_in      = 1'b0;
		sleep_active = 1'b0;
		time_incr    = 1'b0;
		cur          = '{default: 8'h00};
		err_total    = 0;
		tests_run    = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		por_n   <= 1'b1;
		t_reset;
		t_regs;
		t_dow;
		t_alarm;
		t_sleep;
		t_ctrl;
		t_presc;
		t_xtal;
		give_verdict;
	end
endmodule : rtc_alarm_compare_and_control_tb
`default_nettype wire
